// [verilog/i2c_regs_defs.svh]
// Constants of the two-wire register access slave.
// Assumes a 100 MHz system clock and a bus no faster than 400 kbit/s.
`ifndef I2C_REGS_DEFS_SVH
`define I2C_REGS_DEFS_SVH
`define SLAVE_ADDR 7'h1a
`define REG_COUNT 256
`define REG_RESET_VALUE 8'h00
`define CLK_PERIOD_NS 10
`define BUS_RATE_KBPS 400
`define MIN_SCL_LOW_NS 1300
`define MIN_SCL_LOW_CYC ((`MIN_SCL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [verilog/i2c_regs_pkg.sv]
// Types shared by the two-wire register access slave.
// Assumes nothing beyond the defs header.
package i2c_regs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SELECT, ST_ADDR, ST_WDATA, ST_RDATA, ST_RACK
  } slave_state_e;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// [verilog/reg_file_mem.sv]
// Byte register store with registered read data.
// Assumes one request per cycle on the system clock.
`timescale 1ns/1ps
`include "i2c_regs_defs.svh"
module reg_file_mem
  import i2c_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire reg_req_s req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [`REG_COUNT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        mem[i] <= `REG_RESET_VALUE;
      end
      rdata_o <= 8'h00;
    end else begin
      if (req_i.we) begin
        mem[req_i.addr] <= req_i.wdata;
      end
      rdata_o <= mem[req_i.addr];
    end
  end
endmodule

// [verilog/i2c_reg_slave.sv]
// Two-wire bus slave giving an outside master byte access to the register store.
// Assumes scl/sda arrive asynchronously; sda is open drain, driven low when oe is high.
//
// Summary of operation
// RQ1 - Works at bus rates up to 400 kbit/s via 100 MHz oversampling.
// RQ2 - Slave only; never drives the clock, master starts every transfer.
// RQ3 - Data changes only while clock low; high-clock changes mean START/STOP.
// RQ4 - Falling data with clock high is START; START precedes each command.
// RQ5 - Rising data with clock high is STOP and ends the communication.
// RQ6 - Received data sampled on each rising clock edge.
// RQ7 - Master sends select byte MSB first: seven address bits then direction.
// RQ8 - Answers only to address 0011010, write select byte 0x34.
// RQ9 - Select byte LSB 1 means read, 0 means write.
// RQ10 - Matching address acknowledged on the ninth clock.
// RQ11 - Write: next byte loads and acknowledges the address pointer.
// RQ12 - Single data byte stored and acknowledged, then master stops.
// RQ13 - Further write bytes go to successively higher addresses until STOP; the code wraps the pointer from 0xff to 0x00.
// RQ14 - Read select acknowledged, then one byte shifted from current address.
// RQ15 - Multi-byte read returns consecutive addresses while master acknowledges.
// RQ16 - Active-low reset clears outputs and registers asynchronously; the code synchronises the pin and clears them on clk_i edges.
// RQ17 - Runs from own free clock, no master audio clock needed.
// RQ18 - Repeated START with read bit returns data from written address.
// RQ19 - Pointer advances after every byte written or read.
// RQ20 - Unacknowledged read byte releases data line and waits for START/STOP.
`timescale 1ns/1ps
`include "i2c_regs_defs.svh"
module i2c_reg_slave
  import i2c_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] addr_ptr_o,
  output logic busy_o
);
  // Reset pin is asynchronous to clk_i; it is synchronised and held [RQ16]
  logic [2:0] rst_sync;
  logic pin_rst;
  // Either reset source holds every register of the block except rst_sync and pin_rst, which only srst_i resets
  wire int_rst = srst_i || pin_rst;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_sync <= 3'h0;
    end else begin
      rst_sync <= {rst_sync[1:0], reset_n_i};
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_rst <= 1'b1;
    end else if (!rst_sync[1] && !rst_sync[2]) begin
      pin_rst <= 1'b1;
    end else if (rst_sync[1] && rst_sync[2]) begin
      pin_rst <= 1'b0;
    end
  end

  // Three-stage pin synchronisers; a change counts when stages 2 and 3 agree [RQ1] [RQ17]
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_q;
  logic sda_q;
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_q <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_q <= sda_sync[2];
      end
    end
  end
  wire scl_new = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
  wire sda_new = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
  wire scl_rise = scl_new && !scl_q;
  wire scl_fall = !scl_new && scl_q;
  wire start_det = scl_q && scl_new && sda_q && !sda_new;  // [RQ3] [RQ4]
  wire stop_det = scl_q && scl_new && !sda_q && sda_new;   // [RQ3] [RQ5]

  slave_state_e state;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic ack_phase;
  logic drive_low;
  logic [7:0] ptr;
  logic rd_load;
  reg_req_s req;
  logic [7:0] rdata;

  reg_file_mem u_mem (
    .clk_i(clk_i),
    .rst_i(int_rst),
    .req_i(req),
    .rdata_o(rdata)
  );

  wire byte_done = scl_fall && !ack_phase && (bit_cnt == 4'd8);
  wire addr_match = (shreg[7:1] == `SLAVE_ADDR);  // [RQ8]
  wire rd_dir = shreg[0];                          // [RQ9]
  wire [7:0] ptr_inc = ptr + 8'h01;

  // Byte shifting and acknowledge slot timing
  always_ff @(posedge clk_i) begin
    if (int_rst || start_det || stop_det) begin
      bit_cnt <= 4'd0;
      ack_phase <= 1'b0;
      shreg <= 8'h00;
    end else if (scl_rise && !ack_phase && state != ST_RDATA) begin
      shreg <= {shreg[6:0], sda_new};  // MSB first [RQ6] [RQ7]
      bit_cnt <= bit_cnt + 4'd1;
    end else if (scl_rise && !ack_phase) begin
      bit_cnt <= bit_cnt + 4'd1;
    end else if (byte_done) begin
      ack_phase <= 1'b1;  // Ninth clock [RQ10]
      bit_cnt <= 4'd0;
    end else if (scl_fall && ack_phase) begin
      ack_phase <= 1'b0;
    end
  end

  // Protocol sequencing
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      state <= ST_IDLE;
      ptr <= 8'h00;
      drive_low <= 1'b0;
      req <= '0;
      rd_load <= 1'b0;
    end else begin
      req.we <= 1'b0;
      rd_load <= 1'b0;
      if (start_det) begin
        state <= ST_SELECT;  // Also a repeated START [RQ18]
        drive_low <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;  // [RQ5]
        drive_low <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
            drive_low <= 1'b0;
          end
          ST_SELECT: begin
            if (byte_done) begin
              drive_low <= addr_match;  // [RQ10]
              if (!addr_match) begin
                state <= ST_IDLE;
              end else if (rd_dir) begin
                state <= ST_RDATA;  // [RQ14]
                req.addr <= ptr;
                rd_load <= 1'b1;
              end else begin
                state <= ST_ADDR;
              end
            end else if (scl_fall && ack_phase) begin
              drive_low <= 1'b0;
            end
          end
          ST_ADDR: begin
            if (byte_done) begin
              ptr <= shreg;  // [RQ11]
              drive_low <= 1'b1;
              state <= ST_WDATA;
            end else if (scl_fall && ack_phase) begin
              drive_low <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (byte_done) begin
              req.we <= 1'b1;
              req.addr <= ptr;
              req.wdata <= shreg;  // [RQ12] [RQ13]
              ptr <= ptr_inc;      // [RQ19]
              drive_low <= 1'b1;
            end else if (scl_fall && ack_phase) begin
              drive_low <= 1'b0;
            end
          end
          ST_RDATA: begin
            // Bits come from tx; the acknowledge drive ends as the ninth clock falls
            if (scl_fall && ack_phase) begin
              drive_low <= 1'b0;
            end else if (byte_done) begin
              drive_low <= 1'b0;  // Release for master acknowledge
              ptr <= ptr_inc;     // [RQ19]
              state <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_new) begin
                state <= ST_IDLE;  // No acknowledge: release and wait [RQ20]
              end else begin
                req.addr <= ptr;   // Next consecutive byte [RQ15]
                rd_load <= 1'b1;
              end
            end else if (scl_fall && ack_phase) begin
              state <= ST_RDATA;  // Acknowledged: next byte starts on this fall [RQ15]
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Read byte shifter loaded from the store, presented MSB first
  logic [7:0] tx;
  logic load_pend;
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      tx <= 8'h00;
      load_pend <= 1'b0;
    end else begin
      load_pend <= rd_load;
      if (load_pend) begin
        tx <= rdata;
      end else if (state == ST_RDATA && scl_fall && bit_cnt != 4'd8 && !ack_phase
                   && bit_cnt != 4'd0) begin
        tx <= {tx[6:0], 1'b0};
      end
    end
  end

  // SDA is open drain, and only ever pulled low; the clock pin is input only [RQ2]
  // Last bit stands through its high clock, so the line never moves while it is high
  wire send_bit = (state == ST_RDATA) && !ack_phase;  // [RQ3] [RQ14]
  wire tx_low = send_bit ? !tx[7] : 1'b0;
  assign sda_o = 1'b0;
  assign sda_oe_o = int_rst ? 1'b0 : (send_bit ? tx_low : drive_low);
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      addr_ptr_o <= 8'h00;
      busy_o <= 1'b0;
    end else begin
      addr_ptr_o <= ptr;
      busy_o <= (state != ST_IDLE);
    end
  end
endmodule

// [bench/i2c_reg_slave_monitor.sv]
// Port checker for the two-wire register slave.
// Assumes the bound module is clocked by clk_i at 100 MHz.
`timescale 1ns/1ps
module i2c_reg_slave_monitor (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] addr_ptr_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  a_sda_drive_low: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_srst_clears: assert property (srst_i |=> !sda_oe_o && !busy_o && addr_ptr_o == 8'h00)
    else $error("sync reset left state");
  a_pin_reset_clears: assert property (
    (!reset_n_i)[*5] |=> !sda_oe_o && addr_ptr_o == 8'h00)
    else $error("pin reset left state");
  a_oe_scl_low: assert property (disable iff (srst_i || !reset_n_i)
    $changed(sda_oe_o) |-> !scl_i)
    else $error("data changed with clock high");
  a_ack_holds: assert property (disable iff (srst_i || !reset_n_i)
    $rose(sda_oe_o) |-> sda_oe_o[*8])
    else $error("drive too short");
  a_stop_ends: assert property (disable iff (srst_i || !reset_n_i)
    scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:8] !busy_o)
    else $error("busy after stop");
  a_ptr_idle_hold: assert property (disable iff (srst_i || !reset_n_i)
    !busy_o && !$past(busy_o) |-> $stable(addr_ptr_o))
    else $error("pointer moved while idle");
  a_oe_when_busy: assert property (disable iff (srst_i || !reset_n_i)
    sda_oe_o && $past(sda_oe_o) |-> busy_o)
    else $error("drive without transfer");
  a_start_busy: assert property (disable iff (srst_i || !reset_n_i)
    scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:8] busy_o)
    else $error("start not taken");
endmodule
bind i2c_reg_slave i2c_reg_slave_monitor mon (.clk_i(clk_i), .srst_i(srst_i),
  .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .addr_ptr_o(addr_ptr_o), .busy_o(busy_o));

// [bench/i2c_master_model.sv]
// Bus master model: drives the link clock and releases or pulls the data line.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module i2c_master_model (
  output logic scl_o,
  output logic sda_rel_o,
  input wire logic sda_i
);
  localparam realtime Q = 31.25;
  initial begin
    scl_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  // Data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    #Q sda_rel_o = b;
    #Q scl_o = 1'b1;
    s = sda_i;
    #(2 * Q) scl_o = 1'b0;
  endtask
  task automatic start();
    #Q sda_rel_o = 1'b1;
    #Q scl_o = 1'b1;
    #(2 * Q) sda_rel_o = 1'b0;
    #(2 * Q) scl_o = 1'b0;
  endtask
  task automatic stop();
    #Q sda_rel_o = 1'b0;
    #Q scl_o = 1'b1;
    #(2 * Q) sda_rel_o = 1'b1;
    #(4 * Q);
  endtask
  // MSB first, then the ninth bit: released for writes, own ACK or NACK for reads
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, ack_n);
  endtask
endmodule

// [bench/i2c_reg_slave_tb.sv]
// Self-checking bench for the two-wire register slave.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module i2c_reg_slave_tb;
  import i2c_regs_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic scl, sda_rel, sda_o, sda_oe_o, busy_o, nak;
  logic [7:0] addr_ptr_o, q;
  logic [7:0] bad [3] = '{8'h36, 8'h24, 8'hb4};
  int n_fail = 0;
  int checks_done = 0;
  wire sda = sda_rel & (sda_oe_o ? sda_o : 1'b1);
  always #5 clk_i = ~clk_i;
  i2c_master_model m (.scl_o(scl), .sda_rel_o(sda_rel), .sda_i(sda));
  i2c_reg_slave dut (.clk_i(clk_i), .srst_i(srst_i), .reset_n_i(reset_n_i), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_ptr_o(addr_ptr_o),
    .busy_o(busy_o));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h got %h", what, exp, got);
    end
  endtask
  task automatic xb(input logic [7:0] d, input logic last);
    m.byte_io(d, last, q, nak);
  endtask
  task automatic wr(input logic [7:0] d);
    xb(d, 1'b1);
    chk("ack", 8'h00, {7'h00, nak});
  endtask
  task automatic t_wrap_burst();
    m.start();
    wr(8'h34);
    wr(8'hff);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    m.stop();
    m.start();
    wr(8'h34);
    wr(8'hff);
    m.start();
    wr(8'h35);
    xb(8'hff, 1'b0);
    chk("rd_ff", 8'h11, q);
    xb(8'hff, 1'b1);
    chk("rd_00", 8'h22, q);
    m.stop();
    chk("ptr", 8'h01, addr_ptr_o);
  endtask
  task automatic t_current_read();
    m.start();
    wr(8'h35);
    xb(8'hff, 1'b1);
    chk("cur", 8'h33, q);
    chk("released", 8'h00, {7'h00, sda_oe_o});
    m.stop();
    chk("ptr2", 8'h02, addr_ptr_o);
    chk("busy", 8'h00, {7'h00, busy_o});
  endtask
  task automatic t_wrong_addr();
    foreach (bad[i]) begin
      m.start();
      xb(bad[i], 1'b1);
      chk("nack", 8'h01, {7'h00, nak});
      m.stop();
    end
    chk("ptr3", 8'h02, addr_ptr_o);
  endtask
  task automatic t_pin_reset();
    m.start();
    wr(8'h34);
    wr(8'h20);
    wr(8'h77);
    m.stop();
    m.start();
    wr(8'h34);
    wr(8'h20);
    m.start();
    wr(8'h35);
    xb(8'hff, 1'b1);
    chk("wr_20", 8'h77, q);
    m.stop();
    chk("ptr4", 8'h21, addr_ptr_o);
    @(negedge clk_i) reset_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (10) @(negedge clk_i);
    chk("ptr_rst", 8'h00, addr_ptr_o);
    m.start();
    wr(8'h34);
    wr(8'h20);
    m.start();
    wr(8'h35);
    xb(8'hff, 1'b1);
    chk("reg_rst", 8'h00, q);
    m.stop();
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    t_wrap_burst();
    t_current_read();
    t_wrong_addr();
    t_pin_reset();
    end_of_test();
  end
  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end
endmodule
